// ===== logic/tsf_sensor.sv
// tsf_sensor: sensor end of the temperature link, bus slave plus timers
// assumes the link pins are asynchronous and the master keeps its rules
`timescale 1ns/1ps
`include "tsf_map.svh"

module tsf_sensor #(
  parameter int unsigned PU_CYC = `TSF_PU_CYC,
  parameter int unsigned SR_CYC = `TSF_SR_CYC,
  parameter int unsigned MEAS_LO_CYC = `TSF_MEAS_LO_CYC,
  parameter int unsigned MEAS_MD_CYC = `TSF_MEAS_MD_CYC,
  parameter int unsigned MEAS_HI_CYC = `TSF_MEAS_HI_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // link pins
  tsf_if.dev bus,
  // reading and alarm limit from the sensing core
  input wire logic [15:0] temp_i,
  input wire logic [15:0] limit_i,
  // status
  output logic idle_o,
  output logic busy_o,
  output logic result_valid_o
);
  import tsf_pkg::*;

  // synchronisers, stage 1 feeds stage 2 only
  logic [1:0] scl_sq;
  logic [1:0] sda_sq;
  logic [1:0] rstn_sq;
  logic [1:0] sel_sq;
  logic scl_p_q; // previous synced clock level
  logic sda_p_q; // previous synced data level
  logic scl_s;
  logic sda_s;
  logic rstn_s;
  logic sel_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // timers and measurement state
  logic [20:0] tmr_q; // cycles left in recovery or measurement
  logic rec_q; // recovering from power-up or reset
  logic meas_q; // measurement running
  logic ready_q; // result waiting to be read
  logic str_q; // pending result was asked with stretching
  logic [15:0] res_q; // captured reading
  logic idle_q;
  logic alarm_q;

  // bus engine
  tsf_dstate_e state_q;
  logic [3:0] cnt_q; // bit counter
  logic [7:0] sh_q; // receive shifter
  logic [1:0] bidx_q; // byte index in transaction
  logic rw_q; // header read bit
  logic sel_q; // select level caught at start
  logic mack_q; // master acknowledged last byte
  logic rel_q; // first bit set up, release clock next
  logic [15:0] cmd_q;
  logic [15:0] tx_q;
  logic do_cmd_q; // pulse: command word complete
  logic rd_take_q; // pulse: result handed to the bus
  logic sda_oe_q;
  logic scl_oe_q;

  // command decode
  logic m_ok;
  logic m_str;
  logic [20:0] m_dur;

  assign scl_s = scl_sq[1];
  assign sda_s = sda_sq[1];
  assign rstn_s = rstn_sq[1];
  assign sel_s = sel_sq[1];
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  // start and stop only change data while the clock is high
  assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;

  // link pins only pulled low or released
  assign bus.d_scl_o = 1'b0;
  assign bus.d_sda_o = 1'b0;
  assign bus.d_scl_oe = scl_oe_q;
  assign bus.d_sda_oe = sda_oe_q;
  assign bus.limit_alarm_output = alarm_q;
  assign idle_o = idle_q;
  assign busy_o = meas_q;
  assign result_valid_o = ready_q;

  // two-flop synchronisers for every pin and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sq <= 2'b11;
      sda_sq <= 2'b11;
      rstn_sq <= 2'b11;
      sel_sq <= 2'b00;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce_i) begin
      scl_sq <= {scl_sq[0], bus.scl};
      sda_sq <= {sda_sq[0], bus.sda};
      rstn_sq <= {rstn_sq[0], bus.hw_reset_low_pin};
      sel_sq <= {sel_sq[0], bus.bus_id_select_pin};
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // measurement command decode, stretching and duration
  always_comb begin
    m_ok = 1'b1;
    m_str = 1'b1;
    m_dur = 21'(MEAS_HI_CYC);
    case (cmd_q)
      `TSF_CMD_HI_STR: m_dur = 21'(MEAS_HI_CYC);
      `TSF_CMD_MD_STR: m_dur = 21'(MEAS_MD_CYC);
      `TSF_CMD_LO_STR: m_dur = 21'(MEAS_LO_CYC);
      `TSF_CMD_HI_NOS: begin
        m_str = 1'b0;
        m_dur = 21'(MEAS_HI_CYC);
      end
      `TSF_CMD_MD_NOS: begin
        m_str = 1'b0;
        m_dur = 21'(MEAS_MD_CYC);
      end
      `TSF_CMD_LO_NOS: begin
        m_str = 1'b0;
        m_dur = 21'(MEAS_LO_CYC);
      end
      default: m_ok = 1'b0;
    endcase
  end

  // recovery and measurement timer, result capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_q <= 1'b1;
      tmr_q <= 21'(PU_CYC);
      meas_q <= 1'b0;
      ready_q <= 1'b0;
      str_q <= 1'b0;
      res_q <= 16'h0000;
    end else if (ce_i) begin
      if (!rstn_s) begin
        // hold in reset while the pin is low, time runs after it
        rec_q <= 1'b1;
        tmr_q <= 21'(PU_CYC);
        meas_q <= 1'b0;
        ready_q <= 1'b0;
      end else if (do_cmd_q && cmd_q == `TSF_CMD_SOFT_RST) begin
        rec_q <= 1'b1;
        tmr_q <= 21'(SR_CYC);
        meas_q <= 1'b0;
        ready_q <= 1'b0;
      end else if (do_cmd_q && m_ok) begin
        // measurement starts with the acknowledge of its command
        meas_q <= 1'b1;
        tmr_q <= m_dur;
        str_q <= m_str;
        ready_q <= 1'b0;
      end else if (tmr_q != 21'h00_0000) begin
        tmr_q <= tmr_q - 21'h00_0001;
        if (rd_take_q) begin
          ready_q <= 1'b0;
        end
      end else begin
        rec_q <= 1'b0;
        if (meas_q) begin
          // completion sets the flag even if a read takes it now
          meas_q <= 1'b0;
          ready_q <= 1'b1;
          res_q <= temp_i;
        end else if (rd_take_q) begin
          ready_q <= 1'b0;
        end
      end
    end
  end

  // idle indication and alarm level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_q <= 1'b0;
      alarm_q <= 1'b0;
    end else if (ce_i) begin
      idle_q <= !rec_q && !meas_q;
      alarm_q <= temp_i >= limit_i;
    end
  end

  // bus engine: header, command bytes, result bytes, stretching
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DS_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      bidx_q <= 2'b00;
      rw_q <= 1'b0;
      sel_q <= 1'b0;
      mack_q <= 1'b0;
      rel_q <= 1'b0;
      cmd_q <= 16'h0000;
      tx_q <= 16'h0000;
      do_cmd_q <= 1'b0;
      rd_take_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (ce_i) begin
      do_cmd_q <= 1'b0;
      rd_take_q <= 1'b0;
      if (!rstn_s || stop_c) begin
        // reset or stop: let go of both lines
        state_q <= DS_IDLE;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
        rel_q <= 1'b0;
      end else if (start_c) begin
        state_q <= DS_RX;
        cnt_q <= 4'h0;
        bidx_q <= 2'b00;
        sel_q <= sel_s;
        sda_oe_q <= 1'b0;
        scl_oe_q <= 1'b0;
        rel_q <= 1'b0;
      end else begin
        unique case (state_q)
          DS_IDLE: begin
            // waiting for a start condition
          end
          DS_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              if (bidx_q != 2'b00) begin
                sda_oe_q <= 1'b1;
                state_q <= DS_ACK;
              end else if (sh_q[7:1] == tsf_slave_addr(sel_q) &&
                           !rec_q &&
                           (!sh_q[0] || ready_q || (meas_q && str_q))) begin
                rw_q <= sh_q[0];
                sda_oe_q <= 1'b1;
                state_q <= DS_ACK;
              end else begin
                state_q <= DS_IDLE;
              end
            end
          end
          DS_ACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              cnt_q <= 4'h0;
              bidx_q <= bidx_q + 2'b01;
              if (bidx_q == 2'b00 && rw_q) begin
                if (ready_q) begin
                  tx_q <= res_q;
                  sda_oe_q <= !res_q[15];
                  rd_take_q <= 1'b1;
                  state_q <= DS_TX;
                end else begin
                  scl_oe_q <= 1'b1;
                  state_q <= DS_STR;
                end
              end else if (bidx_q == 2'b00) begin
                state_q <= DS_RX;
              end else begin
                cmd_q <= {cmd_q[7:0], sh_q};
                if (bidx_q == 2'b10) begin
                  do_cmd_q <= 1'b1;
                  state_q <= DS_IDLE;
                end else begin
                  state_q <= DS_RX;
                end
              end
            end
          end
          DS_STR: begin
            // hold the clock low until the result exists
            if (rel_q) begin
              rel_q <= 1'b0;
              scl_oe_q <= 1'b0;
              state_q <= DS_TX;
            end else if (ready_q) begin
              tx_q <= res_q;
              sda_oe_q <= !res_q[15];
              rd_take_q <= 1'b1;
              rel_q <= 1'b1;
            end else if (!meas_q) begin
              scl_oe_q <= 1'b0;
              state_q <= DS_IDLE;
            end
          end
          DS_TX: begin
            if (scl_fall) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == 4'h7) begin
                sda_oe_q <= 1'b0;
                state_q <= DS_MACK;
              end else begin
                tx_q <= {tx_q[14:0], 1'b0};
                sda_oe_q <= !tx_q[14];
              end
            end
          end
          DS_MACK: begin
            if (scl_rise) begin
              mack_q <= !sda_s;
            end else if (scl_fall) begin
              if (mack_q && bidx_q == 2'b01) begin
                tx_q <= {tx_q[14:0], 1'b0};
                sda_oe_q <= !tx_q[14];
                cnt_q <= 4'h0;
                bidx_q <= 2'b10;
                state_q <= DS_TX;
              end else begin
                state_q <= DS_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

endmodule : tsf_sensor

// ===== logic/tsf_map.svh
// tsf_map.svh: constants of the temperature sensor bus front end
// assumes a 10 ns system clock on both ends of the two-wire link
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH

// system clock period
`define TSF_CLK_NS 10
// slave addresses for the two levels of the select pin
`define TSF_ADDR_LOW 7'h4A
`define TSF_ADDR_HIGH 7'h4B
// power-up and soft reset recovery, typical 0.5 ms, bound 1 ms
`define TSF_PU_NS 500000
`define TSF_PU_CYC (`TSF_PU_NS / `TSF_CLK_NS)
`define TSF_SR_NS 500000
`define TSF_SR_CYC (`TSF_SR_NS / `TSF_CLK_NS)
// measurement durations, typical figures, all below their bounds
`define TSF_MEAS_LO_NS 2500000
`define TSF_MEAS_LO_CYC (`TSF_MEAS_LO_NS / `TSF_CLK_NS)
`define TSF_MEAS_MD_NS 4500000
`define TSF_MEAS_MD_CYC (`TSF_MEAS_MD_NS / `TSF_CLK_NS)
`define TSF_MEAS_HI_NS 12500000
`define TSF_MEAS_HI_CYC (`TSF_MEAS_HI_NS / `TSF_CLK_NS)
// reset pulse low time, at least 1 us
`define TSF_RST_NS 1000
`define TSF_RST_CYC ((`TSF_RST_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS)
// gap between commands, at least 1 ms
`define TSF_GAP_NS 1000000
`define TSF_GAP_CYC ((`TSF_GAP_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS)
// half period of the bus clock, 500 ns gives 1 MHz
`define TSF_HALF_NS 500
`define TSF_HALF_CYC ((`TSF_HALF_NS + `TSF_CLK_NS - 1) / `TSF_CLK_NS)
// single shot commands, with and without clock stretching
`define TSF_CMD_HI_STR 16'h2C06
`define TSF_CMD_MD_STR 16'h2C0D
`define TSF_CMD_LO_STR 16'h2C10
`define TSF_CMD_HI_NOS 16'h2400
`define TSF_CMD_MD_NOS 16'h240B
`define TSF_CMD_LO_NOS 16'h2416
// soft reset command code, value is arbitrary
`define TSF_CMD_SOFT_RST 16'h30A0

`endif

// ===== logic/tsf_pkg.sv
// tsf_pkg: types and helpers shared by both ends of the sensor link
// assumes tsf_map.svh is on the include path
`include "tsf_map.svh"

package tsf_pkg;

  // sensor end bus states
  typedef enum logic [2:0] {
    DS_IDLE, DS_RX, DS_ACK, DS_STR, DS_TX, DS_MACK
  } tsf_dstate_e;

  // master end states
  typedef enum logic [2:0] {
    MS_IDLE, MS_START, MS_LOW, MS_HIGH, MS_STOP, MS_GAP, MS_RST
  } tsf_mstate_e;

  // slave address chosen by the select pin level
  function automatic logic [6:0] tsf_slave_addr(input logic sel);
    tsf_slave_addr = sel ? `TSF_ADDR_HIGH : `TSF_ADDR_LOW;
  endfunction : tsf_slave_addr

endpackage : tsf_pkg

// ===== logic/tsf_if.sv
// tsf_if: open-drain two-wire link plus reset, select and alarm pins
// assumes external pull-ups, modelled here as the wired-and of enables
`timescale 1ns/1ps

interface tsf_if;
  // master end drivers
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  // sensor end drivers
  logic d_scl_o;
  logic d_scl_oe;
  logic d_sda_o;
  logic d_sda_oe;
  // resolved line levels
  logic scl;
  logic sda;
  // side pins
  logic hw_reset_low_pin;
  logic bus_id_select_pin;
  logic limit_alarm_output;

  // a line is low when any enabled driver pulls it, else pulled high
  assign scl = !((h_scl_oe && !h_scl_o) || (d_scl_oe && !d_scl_o));
  assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

  modport dev (
    input scl, sda, hw_reset_low_pin, bus_id_select_pin,
    output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, limit_alarm_output
  );
  modport host (
    input scl, sda, limit_alarm_output,
    output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
    output hw_reset_low_pin, bus_id_select_pin
  );
endinterface : tsf_if

// ===== logic/tsf_master.sv
// tsf_master: bus master end of the temperature link
// assumes a user that issues one request at a time while busy_o is low
`timescale 1ns/1ps
`include "tsf_map.svh"

module tsf_master #(
  parameter int unsigned HALF_CYC = `TSF_HALF_CYC,
  parameter int unsigned GAP_CYC = `TSF_GAP_CYC,
  parameter int unsigned RST_CYC = `TSF_RST_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // link pins
  tsf_if.host bus,
  // user requests
  input wire logic req_i,
  input wire logic read_i,
  input wire logic [15:0] cmd_i,
  input wire logic sel_i,
  input wire logic hwrst_i,
  // user answers
  output logic busy_o,
  output logic done_o,
  output logic nack_o,
  output logic [15:0] rdata_o,
  output logic alarm_o
);
  import tsf_pkg::*;

  logic [1:0] scl_sq; // line synchronisers
  logic [1:0] sda_sq;
  logic [1:0] alm_sq;
  logic scl_s;
  logic sda_s;
  tsf_mstate_e st_q;
  logic [16:0] cnt_q; // phase timer
  logic [3:0] bit_q; // 0..7 data, 8 acknowledge
  logic [1:0] byte_q; // header, then two bytes
  logic [1:0] step_q; // sub-step of start and stop
  logic rd_q;
  logic [15:0] cmd_q;
  logic sel_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic rstn_q;
  logic busy_q;
  logic done_q;
  logic nack_q;
  logic alarm_q;
  logic [15:0] rdata_q;
  logic [7:0] tbyte; // byte now on the wire
  logic rx_byte; // sensor drives this data byte
  logic drv_low; // pull data low for this bit

  assign scl_s = scl_sq[1];
  assign sda_s = sda_sq[1];
  assign bus.h_scl_o = 1'b0;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_scl_oe = scl_oe_q;
  assign bus.h_sda_oe = sda_oe_q;
  assign bus.hw_reset_low_pin = rstn_q;
  assign bus.bus_id_select_pin = sel_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign nack_o = nack_q;
  assign rdata_o = rdata_q;
  assign alarm_o = alarm_q;

  // bit to send: header, command bytes, or master acknowledge
  always_comb begin
    tbyte = cmd_q[7:0];
    if (byte_q == 2'b00) begin
      tbyte = {tsf_slave_addr(sel_q), rd_q};
    end else if (byte_q == 2'b01) begin
      tbyte = cmd_q[15:8];
    end
    rx_byte = rd_q && byte_q != 2'b00;
    if (bit_q == 4'h8) begin
      drv_low = rx_byte && byte_q == 2'b01; // ack first, nack last
    end else begin
      drv_low = !rx_byte && !tbyte[3'(4'h7 - bit_q)];
    end
  end

  // synchronisers for lines and alarm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sq <= 2'b11;
      sda_sq <= 2'b11;
      alm_sq <= 2'b00;
      alarm_q <= 1'b0;
    end else if (ce_i) begin
      scl_sq <= {scl_sq[0], bus.scl};
      sda_sq <= {sda_sq[0], bus.sda};
      alm_sq <= {alm_sq[0], bus.limit_alarm_output};
      alarm_q <= alm_sq[1];
    end
  end

  // transfer sequencer with clock divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= MS_IDLE;
      cnt_q <= 17'h0_0000;
      bit_q <= 4'h0;
      byte_q <= 2'b00;
      step_q <= 2'b00;
      rd_q <= 1'b0;
      cmd_q <= 16'h0000;
      sel_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rstn_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (ce_i) begin
      done_q <= 1'b0;
      unique case (st_q)
        MS_IDLE: begin
          if (hwrst_i) begin
            rstn_q <= 1'b0;
            cnt_q <= 17'(RST_CYC);
            busy_q <= 1'b1;
            st_q <= MS_RST;
          end else if (req_i) begin
            rd_q <= read_i;
            cmd_q <= cmd_i;
            sel_q <= sel_i;
            nack_q <= 1'b0;
            busy_q <= 1'b1;
            step_q <= 2'b00;
            cnt_q <= 17'(HALF_CYC);
            st_q <= MS_START;
          end
        end
        MS_START: begin
          if (cnt_q != 17'h0_0000) begin
            cnt_q <= cnt_q - 17'h0_0001;
          end else if (step_q == 2'b00) begin
            sda_oe_q <= 1'b1; // start: data falls, clock high
            step_q <= 2'b01;
            cnt_q <= 17'(HALF_CYC);
          end else begin
            scl_oe_q <= 1'b1;
            bit_q <= 4'h0;
            byte_q <= 2'b00;
            cnt_q <= 17'(HALF_CYC);
            st_q <= MS_LOW;
          end
        end
        MS_LOW: begin
          // data changes only in the middle of the low phase
          if (cnt_q == 17'(HALF_CYC / 2)) begin
            sda_oe_q <= drv_low;
          end
          if (cnt_q != 17'h0_0000) begin
            cnt_q <= cnt_q - 17'h0_0001;
          end else begin
            scl_oe_q <= 1'b0;
            cnt_q <= 17'(HALF_CYC);
            st_q <= MS_HIGH;
          end
        end
        MS_HIGH: begin
          // the high phase counts only once the line is seen high
          if (!scl_s) begin
            cnt_q <= 17'(HALF_CYC);
          end else if (cnt_q != 17'h0_0000) begin
            cnt_q <= cnt_q - 17'h0_0001;
          end else begin
            scl_oe_q <= 1'b1;
            cnt_q <= 17'(HALF_CYC);
            st_q <= MS_LOW;
            if (bit_q != 4'h8) begin
              if (rx_byte) begin
                rdata_q <= {rdata_q[14:0], sda_s};
              end
              bit_q <= bit_q + 4'h1;
            end else begin
              bit_q <= 4'h0;
              if ((!rx_byte && sda_s) || byte_q == 2'b10) begin
                nack_q <= !rx_byte && sda_s;
                step_q <= 2'b00;
                st_q <= MS_STOP;
              end else begin
                byte_q <= byte_q + 2'b01;
              end
            end
          end
        end
        MS_STOP: begin
          if (step_q == 2'b00 && cnt_q == 17'(HALF_CYC / 2)) begin
            sda_oe_q <= 1'b1;
          end
          if (step_q == 2'b01 && !scl_s) begin
            cnt_q <= 17'(HALF_CYC);
          end else if (cnt_q != 17'h0_0000) begin
            cnt_q <= cnt_q - 17'h0_0001;
          end else if (step_q == 2'b00) begin
            scl_oe_q <= 1'b0;
            step_q <= 2'b01;
            cnt_q <= 17'(HALF_CYC);
          end else if (step_q == 2'b01) begin
            sda_oe_q <= 1'b0; // stop: data rises, clock high
            step_q <= 2'b10;
            cnt_q <= 17'(HALF_CYC);
          end else begin
            done_q <= 1'b1;
            cnt_q <= 17'(GAP_CYC);
            st_q <= MS_GAP;
          end
        end
        MS_RST: begin
          if (cnt_q != 17'h0_0000) begin
            cnt_q <= cnt_q - 17'h0_0001;
          end else begin
            rstn_q <= 1'b1;
            done_q <= 1'b1;
            cnt_q <= 17'(GAP_CYC);
            st_q <= MS_GAP;
          end
        end
        MS_GAP: begin
          if (cnt_q != 17'h0_0000) begin
            cnt_q <= cnt_q - 17'h0_0001;
          end else begin
            busy_q <= 1'b0;
            st_q <= MS_IDLE;
          end
        end
      endcase
    end
  end

endmodule : tsf_master

// ===== dv/tsf_link_assertions.sv
// tsf_link_assertions: wire checks on the sensor end of the link
// assumes plain copies of the link signals and the sensor's reset
`timescale 1ns/1ps

module tsf_link_assertions (
  // clock and reset of the sensor end
  input wire logic clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic scl,
  input wire logic d_scl_o,
  input wire logic d_scl_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic hw_reset_low_pin
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles since the reset input or the reset pin last ended, saturating; a soft reset command does not restart it
  logic [9:0] rec_q;
  // restart on either reset, hold at the top
  always_ff @(posedge clk_i) begin
    if (rst_i || !hw_reset_low_pin) rec_q <= 10'h000;
    else if (rec_q != 10'h3FF) rec_q <= rec_q + 10'h001;
  end
  a_scl_low_only: assert property (d_scl_o == 1'b0)
    else $error("sensor drives scl high");
  a_sda_low_only: assert property (d_sda_o == 1'b0)
    else $error("sensor drives sda high");
  a_no_early_ack: assert property (d_sda_oe |-> rec_q >= 10'h12C)
    else $error("sensor pulls sda before recovery");
  a_rst_frees_sda: assert property (!hw_reset_low_pin [*6] |-> !d_sda_oe)
    else $error("sda held during reset");
  a_rst_frees_scl: assert property (!hw_reset_low_pin [*6] |-> !d_scl_oe)
    else $error("scl held during reset");
  a_sda_scl_low: assert property ($changed(d_sda_oe) |-> !scl || !$past(scl))
    else $error("sensor moves sda while scl high");
  a_stretch_start: assert property ($rose(d_scl_oe) |-> !$past(scl))
    else $error("stretch begins with scl high");
  a_stretch_bound: assert property ($rose(d_scl_oe) |-> ##[1:600] !d_scl_oe)
    else $error("stretch outlasts measurement");
endmodule : tsf_link_assertions

// ===== dv/temp_sensor_i2c_front_end_test.sv
// temp_sensor_i2c_front_end_test: both link ends joined, user sides driven
// assumes shortened timers so the whole run stays short
`timescale 1ns/1ps
`include "tsf_map.svh"

module temp_sensor_i2c_front_end_test;
  // one measurement and its readout per row
  typedef struct packed {
    logic [15:0] cmd;
    logic sel;
    logic [15:0] temp;
    logic [15:0] lim;
    logic al;
  } tsf_row_s;
  localparam tsf_row_s ROWS [6] = '{
    '{`TSF_CMD_HI_STR, 1'b0, 16'h1234, 16'h2000, 1'b0},
    '{`TSF_CMD_MD_STR, 1'b1, 16'h8000, 16'h8000, 1'b1},
    '{`TSF_CMD_LO_STR, 1'b0, 16'h0000, 16'h0001, 1'b0},
    '{`TSF_CMD_MD_NOS, 1'b1, 16'hFFFF, 16'h0000, 1'b1},
    '{`TSF_CMD_MD_NOS, 1'b0, 16'h7FFF, 16'h8000, 1'b0},
    '{`TSF_CMD_LO_NOS, 1'b1, 16'h0001, 16'h0001, 1'b1}};
  logic clk_i, rst_i, srst, req, rd, sel, hwrst, idle_done, ce;
  logic [15:0] cmd, temp, lim, rdata;
  logic busy, done, nack, alarm, idle, sbusy, rvalid;
  // shortened timers: recovery below the gap, so resets end in idle;
  // high repeatability outlasts the gap, so its read has to stretch
  localparam int unsigned PU = 300, SR = 200, HALF = 10, GAP = 600;
  localparam int unsigned M_LO = 300, M_MD = 400, M_HI = 1000;
  int err_total, check_count, lown, w;
  wire rst_s = rst_i | srst;
  // handshake flags picked by index in waitc
  wire [2:0] st = {idle, done, busy};
  tsf_if bus_if ();
  tsf_sensor #(.PU_CYC(PU), .SR_CYC(SR), .MEAS_LO_CYC(M_LO),
    .MEAS_MD_CYC(M_MD), .MEAS_HI_CYC(M_HI)) i_tsf_sensor (.clk_i(clk_i),
    .rst_i(rst_s), .ce_i(ce), .bus(bus_if), .temp_i(temp), .limit_i(lim),
    .idle_o(idle), .busy_o(sbusy), .result_valid_o(rvalid));
  tsf_master #(.HALF_CYC(HALF), .GAP_CYC(GAP)) i_tsf_master (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .bus(bus_if), .req_i(req),
    .read_i(rd), .cmd_i(cmd), .sel_i(sel), .hwrst_i(hwrst), .busy_o(busy),
    .done_o(done), .nack_o(nack), .rdata_o(rdata), .alarm_o(alarm));
  tsf_link_assertions i_tsf_link_assertions (.clk_i(clk_i), .rst_i(rst_s),
    .scl(bus_if.scl), .d_scl_o(bus_if.d_scl_o), .d_scl_oe(bus_if.d_scl_oe),
    .d_sda_o(bus_if.d_sda_o), .d_sda_oe(bus_if.d_sda_oe),
    .hw_reset_low_pin(bus_if.hw_reset_low_pin));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // counts cycles with the reset pin low
  always @(posedge clk_i) begin
    if (bus_if.hw_reset_low_pin === 1'b0) lown <= lown + 1;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // waits for a flag under a bound, returns at a rising edge
  task automatic waitc(input int i, input logic v, output int n);
    n = 0;
    while (st[i] !== v && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 5000) begin
      err_total++;
      summarize();
    end
    @(posedge clk_i);
  endtask : waitc
  // one transfer or reset pulse, through to the end of the gap
  task automatic xfer(input logic hw, r, input logic [15:0] c, input logic s);
    req <= !hw;
    hwrst <= hw;
    rd <= r;
    cmd <= c;
    sel <= s;
    waitc(0, 1'b1, w);
    req <= 1'b0;
    hwrst <= 1'b0;
    waitc(1, 1'b1, w);
    idle_done = idle;
    waitc(0, 1'b0, w);
  endtask : xfer
  // a hang ends the run
  initial begin
    #500000;
    err_total++;
    summarize();
  end
  initial begin
    {rst_i, srst, req, rd, sel, hwrst, cmd, temp, lim, ce} = '0;
    rst_i = 1'b1;
    err_total = 0;
    check_count = 0;
    lown = 0;
    repeat (16) @(posedge clk_i);
    chk("idle in reset", idle, 1'b0);
    chk("pin in reset", bus_if.hw_reset_low_pin, 1'b1);
    rst_i <= 1'b0;
    // enable held low after reset: recovery must not run meanwhile
    repeat (50) @(posedge clk_i);
    ce <= 1'b1;
    waitc(2, 1'b1, w);
    chk("power up", w >= PU - 1 && w <= PU + 10, 1'b1);
    $display("reset test done");
    foreach (ROWS[k]) begin
      temp <= ROWS[k].temp;
      lim <= ROWS[k].lim;
      xfer(1'b0, 1'b0, ROWS[k].cmd, ROWS[k].sel);
      chk("write nack", nack, 1'b0);
      xfer(1'b0, 1'b1, 16'h0000, ROWS[k].sel);
      chk("read nack", nack, 1'b0);
      chk("read data", rdata, ROWS[k].temp);
      chk("alarm", alarm, ROWS[k].al);
      $display("row %0d done", k);
    end
    xfer(1'b0, 1'b0, `TSF_CMD_HI_NOS, 1'b1);
    chk("nos measuring", sbusy, 1'b1);
    xfer(1'b0, 1'b1, 16'h0000, 1'b1);
    chk("empty read nack", nack, 1'b1);
    chk("result kept", rvalid, 1'b1);
    chk("measure over", sbusy, 1'b0);
    $display("empty read test done");
    xfer(1'b0, 1'b0, `TSF_CMD_SOFT_RST, 1'b0);
    chk("soft reset busy", idle_done, 1'b0);
    chk("soft reset idle", idle, 1'b1);
    chk("soft reset drop", rvalid, 1'b0);
    $display("soft reset test done");
    xfer(1'b1, 1'b0, 16'h0000, 1'b0);
    chk("pulse length", lown >= `TSF_RST_CYC, 1'b1);
    chk("hw reset busy", idle_done, 1'b0);
    chk("hw reset idle", idle, 1'b1);
    $display("hw reset test done");
    srst <= 1'b1;
    @(posedge clk_i);
    srst <= 1'b0;
    xfer(1'b0, 1'b0, `TSF_CMD_HI_STR, 1'b0);
    chk("early nack", nack, 1'b1);
    $display("recovery test done");
    summarize();
  end
endmodule : temp_sensor_i2c_front_end_test
